// >>> hw/hrp_regs.svh
// Bit positions, codes and register indices of the host register port.
// Assumes nothing; included by the package and design files by bare name.
`ifndef HRP_REGS_SVH
`define HRP_REGS_SVH

// ----------------------------------------------------------------------
// Serial command/pointer byte
// ----------------------------------------------------------------------
`define HRP_PTR_LSB      0
`define HRP_PTR_MSB      2
`define HRP_CMD_LSB      3
`define HRP_CMD_MSB      5
`define HRP_CRC_LSB      6
`define HRP_CRC_MSB      7
`define HRP_SHIFT_BIT    0
`define HRP_SHIFT_EN_BIT 1

// ----------------------------------------------------------------------
// DMA command pointer and bus configuration byte
// ----------------------------------------------------------------------
`define HRP_DPTR_LSB     0
`define HRP_DPTR_MSB     4
`define HRP_BCR_SHIFT    0
`define HRP_BCR_IACK_LSB 1
`define HRP_BCR_IACK_MSB 2

// ----------------------------------------------------------------------
// Register indices and lanes
// ----------------------------------------------------------------------
`define HRP_REG_CMD      5'h00
`define HRP_LANE_MSB     7
`define HRP_SER_PTR_W    4
`define HRP_DMA_PTR_W    5

`endif

// >>> hw/hrp_pkg.sv
// Types shared by the host register port modules.
// Assumes hrp_regs.svh is on the include path.
`include "hrp_regs.svh"

package hrp_pkg;

    // ------------------------------------------------------------------
    // Access sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {st_idle, st_read, st_write} hrp_state_t;

    // ------------------------------------------------------------------
    // Serial command and checker reset codes, in encoding order
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        cmd_null, cmd_point_high, cmd_reset_ext_status, cmd_send_abort,
        cmd_int_next_rx, cmd_reset_tx_int, cmd_error_reset,
        cmd_reset_highest_ius
    } hrp_cmd_t;

    typedef enum logic [1:0] {
        crc_null, crc_reset_rx_checker, crc_reset_tx_generator, crc_reset_eom_latch
    } hrp_crc_t;

endpackage

// >>> hw/hrp_ptr_if.sv
// Pointer control bundle between the access sequencer and a pointer unit.
// Assumes one clock domain, clk_sys.
`timescale 1ns/1ps
`default_nettype none

interface hrp_ptr_if #(parameter int W = 4);
    logic         load;
    logic [W-1:0] load_val;
    logic         done;
    logic [W-1:0] ptr;
    logic         armed;
    modport ctl  (output load, output load_val, output done, input ptr, input armed);
    modport unit (input load, input load_val, input done, output ptr, output armed);
endinterface

`default_nettype wire

// >>> hw/hrp_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes d is asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none

module hrp_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // ------------------------------------------------------------------
    // Stages; s1 only feeds s2
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s1 <= RST;
            s2 <= RST;
            s3 <= RST;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Per-bit: a change counts once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            q <= RST;
        end else begin
            q <= (s2 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
        end
    end
endmodule

`default_nettype wire

// >>> hw/hrp_ptr.sv
// Auto-clearing register pointer for one device section.
// Assumes load and done are single-cycle pulses from the sequencer.
`timescale 1ns/1ps
`default_nettype none

module hrp_ptr #(
    parameter int W = 4
) (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    hrp_ptr_if.unit   pif
);
    // ------------------------------------------------------------------
    // Pointer state
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pif.ptr   <= '0;
            pif.armed <= 1'b0;
        end else if (pif.done && pif.armed) begin
            pif.ptr   <= '0;
            pif.armed <= 1'b0;
        end else if (pif.load) begin
            pif.ptr   <= pif.load_val;
            pif.armed <= 1'b1;
        end
    end

    AST_PTR_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pif.done && pif.armed |=> pif.ptr == '0 && !pif.armed)
        else $error("pointer not cleared after second access");

    AST_PTR_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pif.load && !pif.armed |=> pif.armed && pif.ptr == $past(pif.load_val))
        else $error("pointer load lost");
endmodule

`default_nettype wire

// >>> hw/hrp_host_port.sv
// Host register port: slave bus decode into serial and DMA sections.
// Assumes asynchronous host pins and a user-side register file that
// returns reg_rdata combinationally in the cycle of reg_rd.
//
// Function
// - Section/channel selects route to A, B, DMA
// - Select pins inputs as slave, outputs mastering
// - Two modes: direct address or pointer
// - Serial: pointer write, then data access
// - Serial pointer clears after second access
// - No direct serial data access when non-multiplexed
// - Point high moves pointer to 8-15
// - Three-bit serial command field decoded
// - Two-bit checker reset field decoded
// - DMA pointer separate, five bits
// - DMA pointer clears after second access
// - Multiplexed address from AD5-1 or AD4-0
// - Shift choice per section, own source
// - Command low bits select shift mode
// - Slave transfers are single bytes
// - First DMA-side write configures bus, only once
// - Channel select picks wait or ready
// - Address strobe before config means multiplexed
// - Write low lane; read replicated both lanes
`timescale 1ns/1ps
`default_nettype none
`include "hrp_regs.svh"

module hrp_host_port
    import hrp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        ce_b,
    input  wire logic        as_b,
    input  wire logic        rd_b,
    input  wire logic        wr_b,
    input  wire logic [15:0] address_data_bus_in,
    output logic      [15:0] address_data_bus_out,
    output logic             address_data_bus_oe_b,
    input  wire logic        section_select_in,
    output logic             section_select_out,
    output logic             section_select_oe_b,
    input  wire logic        channel_select_in,
    output logic             channel_select_out,
    output logic             channel_select_oe_b,
    output logic             wait_rdy_out,
    output logic             wait_rdy_oe_b,
    input  wire logic        dma_master,
    input  wire logic        dma_section,
    input  wire logic        dma_channel,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic             reg_sect,
    output logic             reg_chan,
    output logic      [4:0]  reg_addr,
    output logic      [7:0]  reg_wdata,
    input  wire logic [7:0]  reg_rdata,
    output logic             ser_cmd_stb,
    output hrp_cmd_t         ser_cmd,
    output hrp_crc_t         ser_crc,
    output logic             ser_cmd_chan,
    output logic             ser_shift_right,
    output logic             cfg_done,
    output logic             mux_mode,
    output logic             wait_mode,
    output logic             dma_shift_right,
    output logic      [1:0]  iack_type
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [3:0]  ctl_q;
    logic [17:0] dat_q;
    logic        ce_q;
    logic        as_q;
    logic        rd_q;
    logic        wr_q;
    logic        sect_q;
    logic        chan_q;
    logic [15:0] ad_q;

    hrp_sync #(.W(4), .RST(4'hf)) u_sync_ctl (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .d       ({ce_b, as_b, rd_b, wr_b}),
        .q       (ctl_q)
    );

    hrp_sync #(.W(18), .RST(18'h00000)) u_sync_dat (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .d       ({section_select_in, channel_select_in, address_data_bus_in}),
        .q       (dat_q)
    );

    assign {ce_q, as_q, rd_q, wr_q} = ctl_q;
    assign {sect_q, chan_q, ad_q}   = dat_q;

    // ------------------------------------------------------------------
    // Section pointers
    // ------------------------------------------------------------------
    hrp_ptr_if #(.W(`HRP_SER_PTR_W)) ser_pif ();
    hrp_ptr_if #(.W(`HRP_DMA_PTR_W)) dma_pif ();

    hrp_ptr #(.W(`HRP_SER_PTR_W)) u_ser_ptr (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pif     (ser_pif)
    );

    hrp_ptr #(.W(`HRP_DMA_PTR_W)) u_dma_ptr (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pif     (dma_pif)
    );

    // ------------------------------------------------------------------
    // Address strobe latch
    // ------------------------------------------------------------------
    logic       as_d;
    logic       as_seen;
    logic       lat_sect;
    logic       lat_chan;
    logic [5:0] lat_ad;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            as_d     <= 1'b1;
            lat_sect <= 1'b0;
            lat_chan <= 1'b0;
            lat_ad   <= 6'h00;
        end else begin
            as_d <= as_q;
            // Address is stable at the trailing edge of the strobe
            if (as_q && !as_d) begin
                lat_sect <= sect_q;
                lat_chan <= chan_q;
                lat_ad   <= ad_q[5:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Target decode
    // ------------------------------------------------------------------
    hrp_state_t state;
    logic       cur_sect;
    logic       cur_chan;
    logic       shift_r;
    logic [4:0] mux_addr;
    logic       ptr_armed;
    logic [4:0] ptr_val;
    logic       is_ptr_reg;
    logic [4:0] tgt_addr;
    logic [7:0] wbyte;
    hrp_cmd_t   wcmd;
    logic       rd_start;
    logic       wr_commit;
    logic       wr_live;

    always_comb begin
        cur_sect  = mux_mode ? lat_sect : sect_q;
        cur_chan  = mux_mode ? lat_chan : chan_q;
        shift_r   = cur_sect ? ser_shift_right : dma_shift_right;
        mux_addr  = shift_r ? lat_ad[4:0] : lat_ad[5:1];
        ptr_armed = cur_sect ? ser_pif.armed : dma_pif.armed;
        ptr_val   = cur_sect ? {1'b0, ser_pif.ptr} : dma_pif.ptr;
        // Direct address when multiplexed, pointer otherwise
        is_ptr_reg = mux_mode ? (mux_addr == `HRP_REG_CMD) : !ptr_armed;
        tgt_addr   = mux_mode ? mux_addr : (ptr_armed ? ptr_val : `HRP_REG_CMD);
        wbyte      = ad_q[`HRP_LANE_MSB:0];
        wcmd       = hrp_cmd_t'(wbyte[`HRP_CMD_MSB:`HRP_CMD_LSB]);
    end

    // Master mode keeps the slave decoder quiet; chip enable gates all
    assign rd_start  = (state == st_idle) && cfg_done && !ce_q && !rd_q && !dma_master;
    assign wr_commit = (state == st_write) && (ce_q || wr_q);
    assign wr_live   = wr_commit && cfg_done;

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state <= st_idle;
        end else begin
            unique case (state)
                st_idle: begin
                    if (rd_start) begin
                        state <= st_read;
                    end else if (!ce_q && !wr_q && !dma_master) begin
                        state <= st_write;
                    end
                end
                st_read: begin
                    if (ce_q || rd_q) begin
                        state <= st_idle;
                    end
                end
                st_write: begin
                    if (wr_commit) begin
                        state <= st_idle;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // One-time bus configuration
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            as_seen         <= 1'b0;
            cfg_done        <= 1'b0;
            mux_mode        <= 1'b0;
            wait_mode       <= 1'b0;
            dma_shift_right <= 1'b0;
            iack_type       <= 2'h0;
        end else begin
            if (!cfg_done && !as_q) begin
                as_seen <= 1'b1;
            end
            // Anything but a DMA-side write is ignored until configured
            if (wr_commit && !cfg_done && !cur_sect) begin
                cfg_done        <= 1'b1;
                mux_mode        <= as_seen;
                wait_mode       <= chan_q;
                dma_shift_right <= wbyte[`HRP_BCR_SHIFT];
                iack_type       <= wbyte[`HRP_BCR_IACK_MSB:`HRP_BCR_IACK_LSB];
            end
        end
    end

    // ------------------------------------------------------------------
    // User-side register strobes
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reg_wr    <= 1'b0;
            reg_rd    <= 1'b0;
            reg_sect  <= 1'b0;
            reg_chan  <= 1'b0;
            reg_addr  <= 5'h00;
            reg_wdata <= 8'h00;
        end else begin
            reg_wr <= wr_live;
            reg_rd <= rd_start;
            if (wr_live || rd_start) begin
                reg_sect <= cur_sect;
                reg_chan <= cur_chan;
                reg_addr <= tgt_addr;
            end
            if (wr_live) begin
                reg_wdata <= wbyte;
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial command decode
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ser_cmd_stb     <= 1'b0;
            ser_cmd         <= cmd_null;
            ser_crc         <= crc_null;
            ser_cmd_chan    <= 1'b0;
            ser_shift_right <= 1'b0;
        end else begin
            ser_cmd_stb <= wr_live && cur_sect && is_ptr_reg;
            if (wr_live && cur_sect && is_ptr_reg) begin
                // Point high has no meaning when addresses are direct
                ser_cmd      <= (mux_mode && wcmd == cmd_point_high) ? cmd_null : wcmd;
                ser_crc      <= hrp_crc_t'(wbyte[`HRP_CRC_MSB:`HRP_CRC_LSB]);
                ser_cmd_chan <= cur_chan;
                if (mux_mode && wbyte[`HRP_SHIFT_EN_BIT]) begin
                    ser_shift_right <= wbyte[`HRP_SHIFT_BIT];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Pointer load and clear pulses
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ser_pif.load     <= 1'b0;
            ser_pif.load_val <= '0;
            ser_pif.done     <= 1'b0;
            dma_pif.load     <= 1'b0;
            dma_pif.load_val <= '0;
            dma_pif.done     <= 1'b0;
        end else begin
            ser_pif.load <= wr_live && !mux_mode && cur_sect && !ser_pif.armed;
            ser_pif.load_val <= {wcmd == cmd_point_high,
                                 wbyte[`HRP_PTR_MSB:`HRP_PTR_LSB]};
            ser_pif.done <= (wr_live || rd_start) && !mux_mode && cur_sect
                            && ser_pif.armed;
            dma_pif.load <= wr_live && !mux_mode && !cur_sect && !dma_pif.armed;
            dma_pif.load_val <= wbyte[`HRP_DPTR_MSB:`HRP_DPTR_LSB];
            dma_pif.done <= (wr_live || rd_start) && !mux_mode && !cur_sect
                            && dma_pif.armed;
        end
    end

    // ------------------------------------------------------------------
    // Read data and pin drive
    // ------------------------------------------------------------------
    logic [7:0] rd_byte;
    logic       rd_valid;
    logic       wait_sel;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rd_byte  <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            if (reg_rd) begin
                rd_byte <= reg_rdata;
            end
            rd_valid <= (state == st_read) && (rd_valid || reg_rd);
        end
    end

    // Byte replicated so either lane of a 16-bit host sees it
    assign address_data_bus_out  = {rd_byte, rd_byte};
    assign address_data_bus_oe_b = !((state == st_read) && rd_valid);

    assign section_select_out  = dma_section;
    assign section_select_oe_b = !dma_master;
    assign channel_select_out  = dma_channel;
    assign channel_select_oe_b = !dma_master;

    // Before configuration the live channel select already picks the style
    assign wait_sel      = cfg_done ? wait_mode : chan_q;
    assign wait_rdy_out  = wait_sel ? !((state == st_read) && !rd_valid)
                                    : !(((state == st_read) && rd_valid)
                                        || (state == st_write));
    assign wait_rdy_oe_b = !(!ce_q && !dma_master);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_SEL_MASTER: assert property (@(posedge clk_sys) disable iff (!rst_b)
        dma_master |-> !section_select_oe_b && section_select_out == dma_section
                       && !channel_select_oe_b)
        else $error("select pins not driven in master mode");

    AST_READ_LANES: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !address_data_bus_oe_b |-> address_data_bus_out[15:8] == address_data_bus_out[7:0]
                                   && ($past(reg_rd) || $past(rd_valid)))
        else $error("read byte not replicated or driven early");

    AST_CFG_ONCE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cfg_done |=> cfg_done && $stable(mux_mode) && $stable(wait_mode)
                     && $stable(iack_type))
        else $error("bus configuration changed after first write");

    AST_NO_ACCESS_UNCONFIGURED: assert property (@(posedge clk_sys) disable iff (!rst_b)
        reg_rd || reg_wr |-> $past(cfg_done))
        else $error("register access before configuration");

    AST_MUX_NO_PTR: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cfg_done && mux_mode |-> !ser_pif.armed && !dma_pif.armed)
        else $error("pointer armed in multiplexed mode");

    AST_SHIFT_SELECT: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ser_cmd_stb && mux_mode && reg_wdata[`HRP_SHIFT_EN_BIT]
            |-> ser_shift_right == reg_wdata[`HRP_SHIFT_BIT])
        else $error("shift mode not taken from command write");

    AST_SER_ADDR_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        reg_wr && reg_sect && !mux_mode |-> reg_addr[4] == 1'b0)
        else $error("serial pointer beyond register 15");

    AST_CMD_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ser_cmd_stb |-> reg_wr && reg_sect && reg_addr == `HRP_REG_CMD ##1 !ser_cmd_stb)
        else $error("command strobe not tied to command register write");
endmodule

`default_nettype wire

// >>> bench/hrp_host_model.sv
// Host processor model: slave bus cycles on the port's strobes.
// Assumes clk_sys shared with the port; address and write strobes held 8 clocks, read strobe 12.
`timescale 1ns/1ps
`default_nettype none

module hrp_host_model (
    input  wire logic        clk_sys,
    input  wire logic [15:0] dev_out,
    input  wire logic        dev_oe_b,
    output logic             ce_b,
    output logic             rd_b,
    output logic             wr_b,
    output logic             as_b,
    output logic             sec,
    output logic             chan,
    output logic      [15:0] ad
);
    logic [15:0] drv = 16'h0000;

    // Released bus shows inverse of the last value
    assign ad = dev_oe_b ? drv : dev_out;

    initial begin
        ce_b = 1'b1;
        rd_b = 1'b1;
        wr_b = 1'b1;
        as_b = 1'b1;
        sec  = 1'b0;
        chan = 1'b0;
    end

    // --------
    // Bus cycles
    // --------
    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Address stands until well after the strobe rises
    task automatic strobe(input logic s, input logic c, input logic [15:0] a);
        sec  <= s;
        chan <= c;
        drv  <= a;
        as_b <= 1'b0;
        hold(8);
        as_b <= 1'b1;
        hold(8);
    endtask

    task automatic wr(input logic s, input logic c, input logic [7:0] d);
        sec  <= s;
        chan <= c;
        drv  <= {~d, d};
        ce_b <= 1'b0;
        hold(4);
        wr_b <= 1'b0;
        hold(8);
        wr_b <= 1'b1;
        hold(8);
        ce_b <= 1'b1;
        drv  <= {d, ~d};
        hold(4);
    endtask

    task automatic rd(input logic s, input logic c, output logic [15:0] q);
        sec  <= s;
        chan <= c;
        drv  <= ~drv;
        ce_b <= 1'b0;
        rd_b <= 1'b0;
        hold(12);
        q = ad;
        rd_b <= 1'b1;
        ce_b <= 1'b1;
        hold(8);
    endtask
endmodule

`default_nettype wire

// >>> bench/dual_section_host_register_port_test.sv
// Self-checking bench of the host register port, both bus modes.
// Assumes hrp_pkg compiled; a mid-run reset switches to multiplexed mode.
`timescale 1ns/1ps
`default_nettype none

module dual_section_host_register_port_test;
    import hrp_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        dma_master = 1'b0;
    logic        ce_b, rd_b, wr_b, sec, chan, oe_b, sel_out, sel_oe_b;
    logic        reg_wr, reg_sect, reg_chan, cfg_done, mux_mode, wait_mode;
    logic        dma_shift_right, as_b, ser_shift_right;
    logic [1:0]  iack_type;
    logic [4:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [15:0] ad, dout, q;
    logic [13:0] wlog = 14'h3fff;
    hrp_cmd_t    ser_cmd;
    hrp_crc_t    ser_crc;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cyc = 0;

    hrp_host_model h (.clk_sys, .dev_out(dout), .dev_oe_b(oe_b), .ce_b, .rd_b,
        .wr_b, .sec, .chan, .ad, .as_b);
    hrp_host_port u_dut (.clk_sys, .rst_b, .ce_b, .as_b, .rd_b, .wr_b,
        .address_data_bus_in(ad), .address_data_bus_out(dout),
        .address_data_bus_oe_b(oe_b), .section_select_in(sec),
        .section_select_out(sel_out), .section_select_oe_b(sel_oe_b),
        .channel_select_in(chan), .channel_select_out(), .channel_select_oe_b(),
        .wait_rdy_out(), .wait_rdy_oe_b(), .dma_master, .dma_section(1'b1),
        .dma_channel(1'b0), .reg_wr, .reg_rd(), .reg_sect, .reg_chan, .reg_addr,
        .reg_wdata, .reg_rdata({reg_sect, reg_chan, 1'b0, reg_addr}),
        .ser_cmd_stb(), .ser_cmd, .ser_crc, .ser_cmd_chan(), .ser_shift_right,
        .cfg_done, .mux_mode, .wait_mode, .dma_shift_right, .iack_type);

    always #10 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (reg_wr === 1'b1) begin
            wlog <= {reg_sect, reg_addr, reg_wdata};
        end
        if (cyc == 4000) begin
            miscompares++;
            end_of_test();
        end
    end

    // --------
    // Checks and scenarios
    // --------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic t_cfg;
        h.rd(1'b1, 1'b1, q);
        chk(q, 16'hffff);
        h.wr(1'b0, 1'b1, 8'h05);
        chk({wlog, 2'b00}, {14'h3fff, 2'b00});
        chk({10'h0, cfg_done, mux_mode, wait_mode, dma_shift_right, iack_type},
            16'h002e);
        dma_master <= 1'b1;
        h.hold(2);
        chk({14'h0, sel_oe_b, sel_out}, 16'h0001);
        dma_master <= 1'b0;
        $display("t_cfg done");
    endtask

    task automatic t_ser;
        h.wr(1'b1, 1'b1, 8'h0b);
        chk({2'b00, wlog}, {3'b001, 5'h00, 8'h0b});
        h.wr(1'b1, 1'b1, 8'h5a);
        chk({2'b00, wlog}, {3'b001, 5'h0b, 8'h5a});
        h.wr(1'b1, 1'b1, 8'h5a);
        chk({2'b00, wlog}, {3'b001, 5'h00, 8'h5a});
        h.rd(1'b1, 1'b1, q);
        chk(q, 16'hc2c2);
        $display("t_ser done");
    endtask

    task automatic t_dma;
        h.wr(1'b0, 1'b0, 8'h13);
        chk({2'b00, wlog}, {3'b000, 5'h00, 8'h13});
        h.wr(1'b0, 1'b0, 8'ha5);
        chk({2'b00, wlog}, {3'b000, 5'h13, 8'ha5});
        h.wr(1'b0, 1'b0, 8'h04);
        h.rd(1'b0, 1'b0, q);
        chk(q, 16'h0404);
        h.wr(1'b0, 1'b0, 8'h66);
        chk({2'b00, wlog}, {3'b000, 5'h00, 8'h66});
        $display("t_dma done");
    endtask

    task automatic t_cmd;
        for (int i = 0; i < 8; i++) begin
            h.wr(1'b1, 1'b0, {i[1:0], i[2:0], 3'd1});
            chk({2'b00, wlog}, {3'b001, 5'h00, i[1:0], i[2:0], 3'd1});
            chk({13'h0, ser_cmd}, 16'(i));
            chk({14'h0, ser_crc}, 16'(i[1:0]));
            h.wr(1'b1, 1'b0, 8'h00);
            chk({2'b00, wlog}, {3'b001, (i == 1) ? 5'h09 : 5'h01, 8'h00});
        end
        $display("t_cmd done");
    endtask

    // Second reset: strobe before the config write selects direct addressing
    task automatic t_mux;
        rst_b <= 1'b0;
        h.hold(2);
        rst_b <= 1'b1;
        h.hold(6);
        chk({14'h0, cfg_done, mux_mode}, 16'h0000);
        h.strobe(1'b0, 1'b0, 16'h0000);
        h.wr(1'b0, 1'b0, 8'h00);
        chk({13'h0, cfg_done, mux_mode, wait_mode}, 16'h0006);
        h.strobe(1'b1, 1'b1, 16'h0000);
        h.wr(1'b1, 1'b1, 8'h03);
        chk({2'b00, wlog}, {3'b001, 5'h00, 8'h03});
        chk({15'h0, ser_shift_right}, 16'h0001);
        h.strobe(1'b1, 1'b1, 16'h0025);
        h.wr(1'b1, 1'b1, 8'h77);
        chk({2'b00, wlog}, {3'b001, 5'h05, 8'h77});
        h.strobe(1'b0, 1'b0, 16'h0025);
        h.wr(1'b0, 1'b0, 8'h3c);
        chk({2'b00, wlog}, {3'b000, 5'h12, 8'h3c});
        $display("t_mux done");
    endtask

    task automatic end_of_test;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Reset held 2 edges; every synchroniser stage clears synchronously
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk_sys);
        t_cfg();
        t_ser();
        t_dma();
        t_cmd();
        t_mux();
        end_of_test();
    end
endmodule

`default_nettype wire
